/* File: frame_stats_pkg.sv */
// Constants shared by the frame statistics register block and its FIFO
package frame_stats_pkg;

    // Register offsets
    localparam logic [6:0] ADDR_EXPOSURE_HIGH = 7'h06;
    localparam logic [6:0] ADDR_EXPOSURE_LOW  = 7'h07;
    localparam logic [6:0] ADDR_PEAK_LEVEL    = 7'h08;
    localparam logic [6:0] ADDR_LEVEL_TOTAL   = 7'h09;
    localparam logic [6:0] ADDR_FLOOR_LEVEL   = 7'h0a;
    localparam logic [6:0] ADDR_CAPTURE_PORT  = 7'h0b;
    localparam logic [6:0] ADDR_POWER_SCALE   = 7'h0d;
    localparam logic [6:0] ADDR_FINE_SCALE    = 7'h19;

    // Field positions
    localparam int CTRL_SLEEP_BIT    = 1;
    localparam int CTRL_SCALE_BIT    = 0;
    localparam int FINE_ENABLE_BIT   = 4;
    localparam int GRAB_VALID_BIT    = 7;

    // Reset values
    localparam logic [7:0]  POWER_SCALE_RESET = 8'h00;
    localparam logic [7:0]  FINE_SCALE_RESET  = 8'h08;
    localparam logic [15:0] EXPOSURE_RESET    = 16'h0100;

    // Pixel format and frame size
    localparam int         PIXEL_W          = 7;
    localparam logic [8:0] PIXELS_PER_FRAME = 9'h169;
    localparam logic [8:0] LAST_PIXEL_POS   = 9'h168;
    localparam logic [6:0] PIXEL_FULL_SCALE = 7'h7f;

    // Stream buffer shape
    localparam int STREAM_W     = 8;
    localparam int STREAM_DEPTH = 16;

    // Scale codes (125 cpi per step)
    localparam logic [3:0] SCALE_CODE_MIN  = 4'h1;
    localparam logic [3:0] SCALE_CODE_MAX  = 4'hb;
    localparam logic [3:0] SCALE_CODE_500  = 4'h4;
    localparam logic [3:0] SCALE_CODE_1000 = 4'h8;

    // Exposure servo limits and targets
    localparam logic [15:0] EXPOSURE_MIN   = 16'h0010;
    localparam logic [15:0] EXPOSURE_MAX   = 16'hf000;
    localparam logic [6:0]  PEAK_HIGH      = 7'h78;
    localparam logic [6:0]  PEAK_LOW       = 7'h50;
    localparam logic [7:0]  TOTAL_HIGH     = 8'h78;
    localparam logic [7:0]  TOTAL_LOW      = 8'h40;
    localparam logic [7:0]  LEVEL_TOTAL_MAX = 8'hb3;

endpackage

/* File: stream_fifo.sv */
// Small synchronous FIFO in front of the frame statistics engine
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and control
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             ce,
    // Fill side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // Drain side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
        logic                        notFull;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  push;
    logic  pop;

    assign outValid = (q.count != '0);
    assign outData  = q.mem[q.rdPtr];
    assign inReady  = q.notFull;

    always_comb begin
        d    = q;
        push = inValid && q.notFull;
        pop  = outValid && outReady;
        if (push) begin
            d.mem[q.wrPtr] = inData;
            d.wrPtr        = q.wrPtr + 1'b1;
        end
        if (pop) begin
            d.rdPtr = q.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            d.count = q.count + 1'b1;
        end else if (pop && !push) begin
            d.count = q.count - 1'b1;
        end
        // Registered so the fill side sees a clean flop
        d.notFull = (d.count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q         <= '0;
            q.notFull <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

/* File: optical_frame_stats_regs.sv */
// Frame statistics, exposure servo, pixel grabber and scale controls
`timescale 1ns/1ps
`default_nettype none
module optical_frame_stats_regs
    import frame_stats_pkg::*;
(
    // Clock, reset, enable
    input  wire logic               clock,
    input  wire logic               srst,
    input  wire logic               ce,
    input  wire logic               hard_reset_n,
    // Register port
    input  wire logic [6:0]         regAddr,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    input  wire logic [7:0]         regWData,
    output logic [7:0]              regRData,
    output logic                    regRValid,
    // Pixel stream from the array
    input  wire logic               pixValid,
    input  wire logic [PIXEL_W-1:0] pixData,
    input  wire logic               pixLast,
    output logic                    pixReady,
    // Controls toward the array and motion logic
    output logic [15:0]             exposureCount,
    output logic                    sleepRequest,
    output logic                    scaleSelect,
    output logic [3:0]              effectiveScale
);

    typedef struct packed {
        logic               hardSync1;
        logic               hardSync2;
        logic               sleep;
        logic               scaleSel;
        logic               fineEn;
        logic [3:0]         fineCode;
        logic [3:0]         effScale;
        logic [15:0]        expo;
        logic [7:0]         expoLowShadow;
        logic [6:0]         peak;
        logic [6:0]         floor;
        logic [7:0]         total;
        logic [6:0]         runMax;
        logic [6:0]         runMin;
        logic [15:0]        runSum;
        logic [8:0]         pos;
        logic [8:0]         grabIdx;
        logic               grabValid;
        logic [6:0]         grabData;
        logic               grabLock;
        logic [7:0]         rdData;
        logic               rdValid;
    } state_s;

    localparam state_s STATE_RESET = '{
        hardSync1:     1'b0,
        hardSync2:     1'b0,
        sleep:         POWER_SCALE_RESET[CTRL_SLEEP_BIT],
        scaleSel:      POWER_SCALE_RESET[CTRL_SCALE_BIT],
        fineEn:        FINE_SCALE_RESET[FINE_ENABLE_BIT],
        fineCode:      FINE_SCALE_RESET[3:0],
        effScale:      SCALE_CODE_500,
        expo:          EXPOSURE_RESET,
        expoLowShadow: 8'h00,
        peak:          7'h00,
        floor:         7'h00,
        total:         8'h00,
        runMax:        7'h00,
        runMin:        7'h00,
        runSum:        16'h0000,
        pos:           9'h000,
        grabIdx:       9'h000,
        grabValid:     1'b0,
        grabData:      7'h00,
        grabLock:      1'b0,
        rdData:        8'h00,
        rdValid:       1'b0
    };

    state_s q;
    state_s d;

    // Buffered pixel stream
    logic                fifoValid;
    logic [STREAM_W-1:0] fifoData;
    logic                fifoReady;
    logic                rstAll;
    logic                pop;
    logic                frameEnd;
    logic [6:0]          pix;
    logic                first;
    logic [6:0]          fMax;
    logic [6:0]          fMin;
    logic [15:0]         fSum;
    logic [7:0]          fTotal;
    logic [15:0]         step;
    logic                grabRd;
    logic                grabWr;

    function automatic logic scaleCodeOk(input logic [3:0] code);
        return (code >= SCALE_CODE_MIN) && (code <= SCALE_CODE_MAX);
    endfunction

    stream_fifo #(
        .WIDTH (STREAM_W),
        .DEPTH (STREAM_DEPTH)
    ) i_stream_fifo (
        .clock    (clock),
        .srst     (rstAll),
        .ce       (ce),
        .inValid  (pixValid),
        .inData   ({pixLast, pixData}),
        .inReady  (pixReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (fifoReady)
    );

    // Sleeping stalls the engine; the buffer then backs up onto the array
    assign fifoReady = !q.sleep && !rstAll;
    assign rstAll    = srst || !q.hardSync2;
    assign pop       = fifoValid && fifoReady;
    assign pix       = fifoData[6:0];
    assign first     = (q.pos == 9'h000);
    assign frameEnd  = pop && (fifoData[7] || (q.pos == LAST_PIXEL_POS));
    assign fMax      = (first || (pix > q.runMax)) ? pix : q.runMax;
    assign fMin      = (first || (pix < q.runMin)) ? pix : q.runMin;
    assign fSum      = (first ? 16'h0000 : q.runSum) + {9'h000, pix};
    // Sum held in 16 bits, bits 15:8 reported, peaks at 179
    assign fTotal    = fSum[15:8];
    assign step      = {4'h0, q.expo[15:4]} + 16'h0001;
    assign grabRd    = regRead && (regAddr == ADDR_CAPTURE_PORT);
    assign grabWr    = regWrite && (regAddr == ADDR_CAPTURE_PORT);

    always_comb begin
        d           = q;
        d.hardSync1 = hard_reset_n;
        d.hardSync2 = q.hardSync1;
        d.rdValid   = 1'b0;

        if (pop) begin
            d.runMax = fMax;
            d.runMin = fMin;
            d.runSum = fSum;
            d.pos    = q.pos + 9'h001;
            if (!q.grabValid && !q.grabLock && (q.pos == q.grabIdx)) begin
                d.grabValid = 1'b1;
                d.grabData  = pix;
                d.grabLock  = 1'b1;
            end
            if (frameEnd) begin
                d.peak     = fMax;
                d.floor    = fMin;
                d.total    = fTotal;
                d.pos      = 9'h000;
                d.grabLock = 1'b0;
                // Servo moves about 1/16 per frame to avoid hunting
                if ((fMax >= PEAK_HIGH) || (fTotal >= TOTAL_HIGH)) begin
                    d.expo = (q.expo > EXPOSURE_MIN + step) ? q.expo - step
                                                            : EXPOSURE_MIN;
                end else if ((fMax < PEAK_LOW) && (fTotal < TOTAL_LOW)) begin
                    d.expo = (q.expo < EXPOSURE_MAX - step) ? q.expo + step
                                                            : EXPOSURE_MAX;
                end
            end
        end

        if (regRead) begin
            d.rdValid = 1'b1;
            unique case (regAddr)
                ADDR_EXPOSURE_HIGH: begin
                    d.rdData        = q.expo[15:8];
                    d.expoLowShadow = q.expo[7:0];
                end
                ADDR_EXPOSURE_LOW:  d.rdData = q.expoLowShadow;
                ADDR_PEAK_LEVEL:    d.rdData = {1'b0, q.peak};
                ADDR_LEVEL_TOTAL:   d.rdData = q.total;
                ADDR_FLOOR_LEVEL:   d.rdData = {1'b0, q.floor};
                ADDR_CAPTURE_PORT: begin
                    if (q.grabValid) begin
                        d.rdData    = {1'b1, q.grabData};
                        d.grabValid = 1'b0;
                        d.grabIdx   = (q.grabIdx == LAST_PIXEL_POS) ? 9'h000
                                                                    : q.grabIdx + 9'h001;
                    end else begin
                        d.rdData = 8'h00;
                    end
                end
                ADDR_POWER_SCALE:   d.rdData = {6'h00, q.sleep, q.scaleSel};
                default:            d.rdData = 8'h00;
            endcase
        end

        if (regWrite) begin
            unique case (regAddr)
                ADDR_CAPTURE_PORT: begin
                    // Mid-frame, lock out the rest: capture restarts at the next image
                    d.grabIdx   = 9'h000;
                    d.grabValid = 1'b0;
                    d.grabLock  = (d.pos != 9'h000);
                end
                ADDR_POWER_SCALE: begin
                    d.sleep    = regWData[CTRL_SLEEP_BIT];
                    d.scaleSel = regWData[CTRL_SCALE_BIT];
                end
                ADDR_FINE_SCALE: begin
                    d.fineEn   = regWData[FINE_ENABLE_BIT];
                    d.fineCode = regWData[3:0];
                end
                default: ;
            endcase
        end

        // Out-of-range fine code keeps the previous scale
        if (d.fineEn) begin
            if (scaleCodeOk(d.fineCode)) begin
                d.effScale = d.fineCode;
            end
        end else begin
            d.effScale = d.scaleSel ? SCALE_CODE_1000 : SCALE_CODE_500;
        end

        if (rstAll) begin
            d           = STATE_RESET;
            d.hardSync1 = hard_reset_n;
            d.hardSync2 = q.hardSync1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q <= STATE_RESET;
        end else if (ce) begin
            q <= d;
        end
    end

    assign regRData       = q.rdData;
    assign regRValid      = q.rdValid;
    assign exposureCount  = q.expo;
    assign sleepRequest   = q.sleep;
    assign scaleSelect    = q.scaleSel;
    assign effectiveScale = q.effScale;

    property p_expo_low_pair;
        @(posedge clock) disable iff (rstAll)
        (ce && regRead && regAddr == ADDR_EXPOSURE_LOW) |=>
            (regRValid && regRData == $past(q.expoLowShadow));
    endproperty
    a_expo_low_pair: assert property (p_expo_low_pair)
        else $error("exposure low byte not from shadow");

    property p_expo_moves_at_frame_end;
        @(posedge clock) disable iff (rstAll)
        (ce && !frameEnd) |=> $stable(q.expo);
    endproperty
    a_expo_moves_at_frame_end: assert property (p_expo_moves_at_frame_end)
        else $error("exposure changed outside a frame end");

    property p_peak_latched;
        @(posedge clock) disable iff (rstAll)
        (ce && frameEnd) |=> (q.peak == $past(fMax) && q.floor <= q.peak);
    endproperty
    a_peak_latched: assert property (p_peak_latched)
        else $error("peak or floor not latched at frame end");

    property p_total_bound;
        @(posedge clock) disable iff (rstAll)
        (ce && frameEnd) |=> (q.total <= LEVEL_TOTAL_MAX && q.total == $past(fTotal));
    endproperty
    a_total_bound: assert property (p_total_bound)
        else $error("level total wrong or above 179");

    property p_grab_valid_read;
        @(posedge clock) disable iff (rstAll)
        (ce && grabRd && q.grabValid && !regWrite) |=>
            (regRData[GRAB_VALID_BIT] && !q.grabValid &&
             (q.grabIdx == $past(q.grabIdx) + 9'h001 || q.grabIdx == 9'h000));
    endproperty
    a_grab_valid_read: assert property (p_grab_valid_read)
        else $error("valid grab read did not advance");

    property p_grab_empty_read;
        @(posedge clock) disable iff (rstAll)
        (ce && grabRd && !q.grabValid && !regWrite) |=>
            (regRData == 8'h00 && q.grabIdx == $past(q.grabIdx));
    endproperty
    a_grab_empty_read: assert property (p_grab_empty_read)
        else $error("empty grab read changed index or set top bit");

    property p_grab_write;
        @(posedge clock) disable iff (rstAll)
        (ce && grabWr) |=>
            (q.grabIdx == 9'h000 && !q.grabValid && q.grabLock == (q.pos != 9'h000));
    endproperty
    a_grab_write: assert property (p_grab_write)
        else $error("grab write did not rearm at pixel zero");

    property p_grab_index_range;
        @(posedge clock) disable iff (rstAll)
        q.grabIdx < PIXELS_PER_FRAME;
    endproperty
    a_grab_index_range: assert property (p_grab_index_range)
        else $error("grab index beyond image");

    property p_one_grab_per_frame;
        @(posedge clock) disable iff (rstAll)
        (ce && $rose(q.grabValid)) |->
            ($past(pop) && ($past(q.pos) == $past(q.grabIdx)) && !$past(q.grabLock));
    endproperty
    a_one_grab_per_frame: assert property (p_one_grab_per_frame)
        else $error("capture without stream pixel or lock");

    property p_fine_scale;
        @(posedge clock) disable iff (rstAll)
        (ce && regWrite && regAddr == ADDR_FINE_SCALE && regWData[FINE_ENABLE_BIT] &&
         regWData[3:0] >= SCALE_CODE_MIN && regWData[3:0] <= SCALE_CODE_MAX) |=>
            ({4'h0, effectiveScale} == ($past(regWData) & 8'h0f));
    endproperty
    a_fine_scale: assert property (p_fine_scale)
        else $error("enabled fine code not applied");

    property p_ctrl_read;
        @(posedge clock) disable iff (rstAll)
        (ce && regRead && regAddr == ADDR_POWER_SCALE) |=>
            (regRData == {6'h00, $past(sleepRequest), $past(scaleSelect)});
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read mismatch");

endmodule
`default_nettype wire

/* File: pixel_source_model.sv */
// Pixel array model feeding whole frames into the statistics stream
`timescale 1ns/1ps
`default_nettype none
module pixel_source_model (
    // Clock and frame request
    input  wire logic       clock,
    input  wire logic       start,
    input  wire logic       kind,
    // Stream toward the block
    input  wire logic       pixReady,
    output logic            pixValid,
    output logic [6:0]      pixData,
    output logic            pixLast,
    // Status
    output logic            busy
);
    int   pos;
    logic took;
    logic kindQ;

    // Kind 0 is a dim textured frame, kind 1 a saturated one
    function automatic logic [6:0] pixel(input logic k, input int i);
        if (k) return 7'h7f;
        if (i == 100) return 7'h46;
        if (i == 200) return 7'h05;
        return 7'(20 + i % 3);
    endfunction

    initial begin
        pixValid = 1'b0;
        pixData  = 7'h55;
        pixLast  = 1'b0;
        busy     = 1'b0;
        pos      = 0;
        took     = 1'b0;
        kindQ    = 1'b0;
    end

    always @(posedge clock) begin
        took <= pixValid && pixReady;
    end

    // Holds each pixel until it is taken; idle data toggles so nothing stale looks valid
    always @(negedge clock) begin
        if (start && !busy) begin
            busy     <= 1'b1;
            pos      <= 0;
            kindQ    <= kind;
            pixValid <= 1'b1;
            pixData  <= pixel(kind, 0);
            pixLast  <= 1'b0;
        end else if (busy && took) begin
            if (pos == 360) begin
                busy     <= 1'b0;
                pixValid <= 1'b0;
                pixLast  <= 1'b0;
                pixData  <= ~pixData;
            end else begin
                pos     <= pos + 1;
                pixData <= pixel(kindQ, pos + 1);
                pixLast <= (pos + 1 == 360);
            end
        end else if (!busy) begin
            pixData <= ~pixData;
        end
    end
endmodule
`default_nettype wire

/* File: optical_frame_stats_regs_bench.sv */
// Register-level bench for the frame statistics block
`timescale 1ns/1ps
`default_nettype none
module optical_frame_stats_regs_bench;
    import frame_stats_pkg::*;
    logic        clock, srst, ce, hardResetN, regWrite, regRead, regRValid;
    logic        pixValid, pixLast, pixReady, sleepRequest, scaleSelect, start, busy, kind;
    logic [6:0]  regAddr, pixData;
    logic [7:0]  regWData, regRData;
    logic [15:0] exposureCount, expo;
    logic [3:0]  effectiveScale, scaleExp;
    int          badCount, checked;

    optical_frame_stats_regs i_optical_frame_stats_regs (
        .clock(clock), .srst(srst), .ce(ce), .hard_reset_n(hardResetN),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWData(regWData),
        .regRData(regRData), .regRValid(regRValid),
        .pixValid(pixValid), .pixData(pixData), .pixLast(pixLast), .pixReady(pixReady),
        .exposureCount(exposureCount), .sleepRequest(sleepRequest),
        .scaleSelect(scaleSelect), .effectiveScale(effectiveScale));

    pixel_source_model i_pixel_source_model (
        .clock(clock), .start(start), .kind(kind), .pixReady(pixReady),
        .pixValid(pixValid), .pixData(pixData), .pixLast(pixLast), .busy(busy));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic endOfTest;
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr  = a;
        regWData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
    endtask

    // Answer arrives one cycle after the strobe and is sampled mid-cycle
    task automatic rdChk(input string what, input logic [6:0] a, input logic [7:0] exp);
        @(negedge clock);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        chk("read valid", 16'h0001, {15'h0000, regRValid});
        chk(what, {8'h00, exp}, {8'h00, regRData});
    endtask

    task automatic waitBusy(input logic lvl);
        for (int n = 0; n < 3000 && busy !== lvl; n++) @(negedge clock);
        if (busy !== lvl) begin
            chk("frame source busy", {15'h0000, lvl}, {15'h0000, busy});
            endOfTest();
        end
    endtask

    task automatic startFrame(input logic k);
        @(negedge clock);
        kind  = k;
        start = 1'b1;
        waitBusy(1'b1);
        start = 1'b0;
    endtask

    // Statistics and servo step worked out from the frame content
    task automatic expectFrame(input logic k);
        logic [6:0]  pk, fl, p;
        logic [15:0] sum, step;
        logic [7:0]  tot;
        waitBusy(1'b0);
        tick(20);
        pk  = 7'h00;
        fl  = 7'h7f;
        sum = 16'h0000;
        for (int i = 0; i < int'(PIXELS_PER_FRAME); i++) begin
            p   = i_pixel_source_model.pixel(k, i);
            pk  = (p > pk) ? p : pk;
            fl  = (p < fl) ? p : fl;
            sum = sum + 16'(p);
        end
        tot  = sum[15:8];
        step = expo / 16 + 1;
        if (pk >= PEAK_HIGH || tot >= TOTAL_HIGH) begin
            expo = (expo - step < EXPOSURE_MIN) ? EXPOSURE_MIN : expo - step;
        end else if (pk < PEAK_LOW && tot < TOTAL_LOW) begin
            expo = (expo > EXPOSURE_MAX - step) ? EXPOSURE_MAX : expo + step;
        end
        rdChk("peak", ADDR_PEAK_LEVEL, {1'b0, pk});
        rdChk("floor", ADDR_FLOOR_LEVEL, {1'b0, fl});
        rdChk("total", ADDR_LEVEL_TOTAL, tot);
        rdChk("exposure high", ADDR_EXPOSURE_HIGH, expo[15:8]);
        rdChk("exposure low", ADDR_EXPOSURE_LOW, expo[7:0]);
        chk("exposure port", expo, exposureCount);
    endtask

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        hardResetN = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 7'h00;
        regWData = 8'h00;
        start = 1'b0;
        kind = 1'b0;
        badCount = 0;
        checked = 0;
        expo = EXPOSURE_RESET;
        repeat (16) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        tick(3);

        rdChk("control reset", ADDR_POWER_SCALE, 8'h00);
        rdChk("fine scale read", ADDR_FINE_SCALE, 8'h00);
        rdChk("exposure high reset", ADDR_EXPOSURE_HIGH, EXPOSURE_RESET[15:8]);
        rdChk("exposure low reset", ADDR_EXPOSURE_LOW, EXPOSURE_RESET[7:0]);
        rdChk("peak reset", ADDR_PEAK_LEVEL, 8'h00);
        rdChk("total reset", ADDR_LEVEL_TOTAL, 8'h00);
        rdChk("floor reset", ADDR_FLOOR_LEVEL, 8'h00);
        rdChk("grab reset", ADDR_CAPTURE_PORT, 8'h00);
        rdChk("unmapped", 7'h0c, 8'h00);
        chk("scale reset", 16'h0004, {12'h000, effectiveScale});
        $display("test reset values finished");

        for (int v = 0; v < 4; v++) begin
            wr(ADDR_POWER_SCALE, 8'(v));
            rdChk("control", ADDR_POWER_SCALE, 8'(v));
            chk("sleep", 16'(v[CTRL_SLEEP_BIT]), {15'h0000, sleepRequest});
            chk("scale bit", 16'(v[CTRL_SCALE_BIT]), {15'h0000, scaleSelect});
            chk("scale", v[0] ? 16'h0008 : 16'h0004, {12'h000, effectiveScale});
        end
        wr(ADDR_POWER_SCALE, 8'h00);
        $display("test control register finished");

        // Out-of-range codes keep whatever scale was active before
        scaleExp = 4'h4;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_FINE_SCALE, 8'h10 | 8'(c));
            if (c >= SCALE_CODE_MIN && c <= SCALE_CODE_MAX) scaleExp = 4'(c);
            chk("fine scale", {12'h000, scaleExp}, {12'h000, effectiveScale});
        end
        wr(ADDR_FINE_SCALE, 8'h05);
        chk("fine disabled", 16'h0004, {12'h000, effectiveScale});
        wr(ADDR_POWER_SCALE, 8'h01);
        chk("fine disabled hi", 16'h0008, {12'h000, effectiveScale});
        wr(ADDR_POWER_SCALE, 8'h00);
        wr(ADDR_FINE_SCALE, FINE_SCALE_RESET);
        $display("test fine scale finished");

        wr(ADDR_CAPTURE_PORT, 8'h00);
        startFrame(1'b0);
        expectFrame(1'b0);
        rdChk("grab pixel 0", ADDR_CAPTURE_PORT, 8'h94);
        rdChk("grab empty", ADDR_CAPTURE_PORT, 8'h00);
        // Asleep the engine stops draining, so the buffer must fill and refuse
        wr(ADDR_POWER_SCALE, 8'h02);
        startFrame(1'b0);
        tick(40);
        chk("buffer full", 16'h0000, {15'h0000, pixReady});
        wr(ADDR_POWER_SCALE, 8'h00);
        expectFrame(1'b0);
        rdChk("grab pixel 1", ADDR_CAPTURE_PORT, 8'h95);
        startFrame(1'b1);
        expectFrame(1'b1);
        rdChk("grab pixel 2", ADDR_CAPTURE_PORT, 8'hff);
        wr(ADDR_CAPTURE_PORT, 8'h5a);
        rdChk("grab after rearm", ADDR_CAPTURE_PORT, 8'h00);
        startFrame(1'b0);
        expectFrame(1'b0);
        rdChk("grab restart", ADDR_CAPTURE_PORT, 8'h94);
        $display("test frames and grabber finished");
        // Pin reset mid-run must clear the controls and the servo
        wr(ADDR_POWER_SCALE, 8'h03);
        hardResetN = 1'b0;
        tick(4);
        hardResetN = 1'b1;
        tick(4);
        rdChk("control pin reset", ADDR_POWER_SCALE, 8'h00);
        chk("sleep pin reset", 16'h0000, {15'h0000, sleepRequest});
        chk("scale pin reset", 16'h0004, {12'h000, effectiveScale});
        chk("exposure pin reset", EXPOSURE_RESET, exposureCount);
        $display("test pin reset finished");
        endOfTest();
    end
endmodule
`default_nettype wire
